// *** rwap_defs.svh ***
`ifndef RWAP_DEFS_SVH
`define RWAP_DEFS_SVH

// ==========================================================
// register offsets
`define RWAP_CFG_OFS      12'h000
`define RWAP_FORM_OFS     12'h004
`define RWAP_ADDR_OFS     12'h008
`define RWAP_OPCMD_OFS    12'h00C
`define RWAP_STAT_OFS     12'h010

// ==========================================================
// reset values
`define RWAP_CFG_RST      8'h00
`define RWAP_FORM_RST     4'h0
`define RWAP_ADDR_RST     23'h00_0000
`define RWAP_KIND_RST     2'h0

// ==========================================================
// status field positions
`define RWAP_ST_REFUSED   0
`define RWAP_ST_ACCEPTED  1
`define RWAP_ST_CNT_LSB   2
`define RWAP_ST_WAITING   6
`define RWAP_ST_DRIVING   7

// ==========================================================
// array geometry
`define RWAP_ARRAY_END    24'h80_0000
`define RWAP_ADDR_MAX     23'h7F_FFFF
`define RWAP_SECTOR_BASE  24'h00_0800
`define RWAP_SECTOR_CAP   24'h00_8000
`define RWAP_BLOCK_BASE   24'h01_0000
`define RWAP_PAGE_MASK    23'h00_00FF
`define RWAP_SECT_MASK    23'h00_0FFF
`define RWAP_BLK_MASK     23'h00_FFFF

`endif

// *** rwap_dummy_lut.sv ***
`timescale 1ns/100ps

module rwap_dummy_lut (
  input  wire rwap_pkg::rwap_form_t form_i,
  input  wire logic [1:0]           wait_sel_i,
  output logic      [3:0]           count_o
);

  // ==========================================================
  // dummy clock table
  always_comb begin
    unique case (form_i)
      rwap_pkg::RWAP_FAST,
      rwap_pkg::RWAP_DUAL_OUT,
      rwap_pkg::RWAP_QUAD_OUT: count_o = 4'h8;
      rwap_pkg::RWAP_DUAL_IO,
      rwap_pkg::RWAP_QUAD_WORD: begin
        count_o = wait_sel_i[0] ? 4'h8 : 4'h4;
      end
      rwap_pkg::RWAP_QUAD_IO,
      rwap_pkg::RWAP_DTR_FAST,
      rwap_pkg::RWAP_DTR_DUAL_IO: begin
        unique case (wait_sel_i)
          2'b00: count_o = 4'h6;
          2'b01: count_o = 4'h4;
          2'b10: count_o = 4'h8;
          2'b11: count_o = 4'hA;
        endcase
      end
      rwap_pkg::RWAP_DTR_QUAD_IO: begin
        unique case (wait_sel_i)
          2'b00: count_o = 4'h8;
          2'b01: count_o = 4'h4;
          2'b10: count_o = 4'h6;
          2'b11: count_o = 4'hA;
        endcase
      end
      // unknown form codes fall back to the safe, longest common wait
      default: count_o = 4'h8;
    endcase
  end

endmodule : rwap_dummy_lut

// *** rwap_host_model.sv ***
`timescale 1ns/100ps

// ==========================================================
// host side: frames chip select and serial clock for one read
module rwap_host_model (
  input  wire logic go_i,
  input  wire logic slow_i,
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      busy_o
);
  realtime half;

  // clock stands still low outside frames
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    busy_o = 1'b0;
  end

  // no address phase is sent, so a quad read always starts aligned
  // status reads are not issued, so reserved bits are never relied on
  always @(posedge go_i) begin
    half   = slow_i ? 64.0 : 32.0;
    busy_o = 1'b1;
    cs_n_o = 1'b0;
    #100;
    // twelve rises cover the longest wait plus two data clocks
    repeat (12) begin
      #(half) sclk_o = 1'b1;
      #(half) sclk_o = 1'b0;
    end
    #100 cs_n_o = 1'b1;
    #100 busy_o = 1'b0;
  end
endmodule : rwap_host_model

// *** rwap_pkg.sv ***
package rwap_pkg;

  // ==========================================================
  // read instruction forms
  typedef enum logic [3:0] {
    RWAP_FAST        = 4'h0,
    RWAP_DUAL_OUT    = 4'h1,
    RWAP_QUAD_OUT    = 4'h2,
    RWAP_DUAL_IO     = 4'h3,
    RWAP_QUAD_WORD   = 4'h4,
    RWAP_QUAD_IO     = 4'h5,
    RWAP_DTR_FAST    = 4'h6,
    RWAP_DTR_DUAL_IO = 4'h7,
    RWAP_DTR_QUAD_IO = 4'h8
  } rwap_form_t;

  // ==========================================================
  // program or erase region kinds
  typedef enum logic [1:0] {
    RWAP_PAGE   = 2'b00,
    RWAP_SECTOR = 2'b01,
    RWAP_BLOCK  = 2'b10,
    RWAP_CHIP   = 2'b11
  } rwap_kind_t;

  // ==========================================================
  // read sequencer states
  typedef enum logic [1:0] {
    RWAP_ST_IDLE = 2'b00,
    RWAP_ST_WAIT = 2'b01,
    RWAP_ST_DATA = 2'b10
  } rwap_state_t;

  // ==========================================================
  // configuration word
  typedef struct packed {
    logic       invert_protection;
    logic [2:0] protect_size_code;
    logic       protect_from_low_end;
    logic       small_unit_select;
    logic [1:0] read_wait_select;
  } rwap_cfg_t;

  // protected window, inclusive bounds
  typedef struct packed {
    logic        en;
    logic [22:0] lo;
    logic [22:0] hi;
  } rwap_range_t;

endpackage : rwap_pkg

// *** rwap_prot_range.sv ***
`timescale 1ns/100ps
`include "rwap_defs.svh"

module rwap_prot_range (
  input  wire rwap_pkg::rwap_cfg_t   cfg_i,
  output rwap_pkg::rwap_range_t      range_o
);

  logic [23:0] sz;
  logic [2:0]  code;

  assign code = cfg_i.protect_size_code;

  // ==========================================================
  // protected window before inversion
  always_comb begin
    sz = 24'h00_0000;
    if (cfg_i.small_unit_select) begin
      sz = code[2] ? `RWAP_SECTOR_CAP : (`RWAP_SECTOR_BASE << code[1:0]);
    end else begin
      sz = `RWAP_BLOCK_BASE << code;
    end
    range_o.en = (code != 3'h0);
    if (code == 3'h7) begin
      range_o.lo = 23'h00_0000;
      range_o.hi = `RWAP_ADDR_MAX;
    end else if (cfg_i.protect_from_low_end) begin
      range_o.lo = 23'h00_0000;
      range_o.hi = 23'(sz - 24'h00_0001);
    end else begin
      range_o.lo = 23'(`RWAP_ARRAY_END - sz);
      range_o.hi = `RWAP_ADDR_MAX;
    end
  end

endmodule : rwap_prot_range

// *** rwap_top.sv ***
// The register offsets and register access over APB were chosen for this implementation.
`timescale 1ns/100ps
`include "rwap_defs.svh"

// Operation
// - two-bit read wait select, reset to 00, chooses dummy clocks per read form
// - single rate fast, dual output, quad output reads always wait 8 clocks
// - single rate dual io and quad word reads wait 4 or 8 clocks
// - single rate quad io read waits 6, 4, 8 or 10 clocks
// - double rate fast and dual io reads wait 6, 4, 8 or 10 clocks
// - double rate quad io read waits 8, 4, 6 or 10 clocks
// - reserved bits read as zero; writing them has no effect
// - size code zero protects nothing, all ones protects the whole array
// - block units from top protect 2 to 64 blocks ending at top
// - block units from low end protect 128KB up to 4MB from zero
// - sector units from top protect top 4KB, 8KB, 16KB or 32KB
// - sector units from low end protect lowest 4KB to 32KB
// - program or erase touching any protected address is refused
// - small unit select picks 4KB sectors, else 64KB blocks, reset clear
// - inversion swaps protected and unprotected regions
module rwap_top (
  input  wire logic        core_clk_i,
  input  wire logic        resetn_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [31:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic             pready_o,
  output logic      [31:0] prdata_o,
  output logic             pslverr_o,
  input  wire logic        sclk_i,
  input  wire logic        cs_n_i,
  output logic             dummy_active_o,
  output logic             data_drive_o,
  output logic             op_go_o,
  output logic             op_refused_o
);

  // ==========================================================
  // declarations
  rwap_pkg::rwap_cfg_t   cfg_q;
  rwap_pkg::rwap_form_t  form_q;
  rwap_pkg::rwap_kind_t  kind_q;
  rwap_pkg::rwap_state_t st_q;
  rwap_pkg::rwap_range_t rng;
  logic [22:0] op_addr_q;
  logic [3:0]  lut_cnt;
  logic [3:0]  dcnt_q;
  logic [3:0]  cnt_lat_q;
  logic        chk_q;
  logic        accepted_q;
  logic        sclk_s1_q;
  logic        sclk_s2_q;
  logic        sclk_s3_q;
  logic        cs_s1_q;
  logic        cs_s2_q;
  logic        cs_s3_q;
  logic        sclk_rise;
  logic        cs_fall;
  logic        setup_rd;
  logic        acc;
  logic        mapped;
  logic        hit;
  logic [22:0] msk;
  logic [22:0] rg_lo;
  logic [22:0] rg_hi;
  logic [31:0] rd_mux;
  logic [7:0]  stat;

  // ==========================================================
  // table and range helpers
  rwap_dummy_lut u_lut (
    .form_i     (form_q),
    .wait_sel_i (cfg_q.read_wait_select),
    .count_o    (lut_cnt)
  );

  rwap_prot_range u_range (
    .cfg_i   (cfg_q),
    .range_o (rng)
  );

  // ==========================================================
  // pin synchronisers: the first stage feeds only the second
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      sclk_s1_q <= 1'b0;
      sclk_s2_q <= 1'b0;
      sclk_s3_q <= 1'b0;
      cs_s1_q   <= 1'b1;
      cs_s2_q   <= 1'b1;
      cs_s3_q   <= 1'b1;
    end else begin
      sclk_s1_q <= sclk_i;
      sclk_s2_q <= sclk_s1_q;
      sclk_s3_q <= sclk_s2_q;
      cs_s1_q <= cs_n_i;
      cs_s2_q <= cs_s1_q;
      cs_s3_q <= cs_s2_q;
    end
  end

  assign sclk_rise = sclk_s2_q && !sclk_s3_q;
  assign cs_fall   = cs_s3_q && !cs_s2_q;

  // ==========================================================
  // apb decode, one wait state on every access
  assign mapped = (paddr_i[31:12] == 20'h0_0000) &&
                  ((paddr_i[11:0] == `RWAP_CFG_OFS)   ||
                   (paddr_i[11:0] == `RWAP_FORM_OFS)  ||
                   (paddr_i[11:0] == `RWAP_ADDR_OFS)  ||
                   (paddr_i[11:0] == `RWAP_OPCMD_OFS) ||
                   (paddr_i[11:0] == `RWAP_STAT_OFS));
  assign setup_rd = psel_i && penable_i && !pready_o;
  assign acc      = psel_i && penable_i && pready_o;

  assign stat = {data_drive_o, dummy_active_o, cnt_lat_q,
                 accepted_q, op_refused_o};

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (paddr_i[11:0])
      `RWAP_CFG_OFS:   rd_mux = {24'h00_0000, cfg_q};
      `RWAP_FORM_OFS:  rd_mux = {28'h000_0000, form_q};
      `RWAP_ADDR_OFS:  rd_mux = {9'h000, op_addr_q};
      `RWAP_OPCMD_OFS: rd_mux = {30'h0000_0000, kind_q};
      `RWAP_STAT_OFS:  rd_mux = {24'h00_0000, stat};
      default:         rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      pready_o  <= 1'b0;
      prdata_o  <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else begin
      pready_o  <= setup_rd;
      pslverr_o <= setup_rd && !mapped;
      if (setup_rd && !pwrite_i && mapped) begin
        prdata_o <= rd_mux;
      end else if (setup_rd) begin
        prdata_o <= 32'h0000_0000;
      end
    end
  end

  // ==========================================================
  // software-written registers
  // upper cfg bits are not stored, so writing them changes nothing
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      cfg_q <= `RWAP_CFG_RST;
    end else if (acc && pwrite_i && paddr_i[31:0] == 32'h0000_0000) begin
      cfg_q <= pwdata_i[7:0];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      form_q    <= rwap_pkg::rwap_form_t'(`RWAP_FORM_RST);
      op_addr_q <= `RWAP_ADDR_RST;
      kind_q    <= rwap_pkg::rwap_kind_t'(`RWAP_KIND_RST);
      chk_q     <= 1'b0;
    end else begin
      chk_q <= 1'b0;
      if (acc && pwrite_i && mapped) begin
        unique case (paddr_i[11:0])
          `RWAP_FORM_OFS: begin
            form_q <= rwap_pkg::rwap_form_t'(pwdata_i[3:0]);
          end
          `RWAP_ADDR_OFS:  op_addr_q <= pwdata_i[22:0];
          `RWAP_OPCMD_OFS: begin
            kind_q <= rwap_pkg::rwap_kind_t'(pwdata_i[1:0]);
            chk_q  <= 1'b1;
          end
          default: chk_q <= 1'b0;
        endcase
      end
    end
  end

  // ==========================================================
  // program and erase screening
  always_comb begin
    unique case (kind_q)
      rwap_pkg::RWAP_PAGE:   msk = `RWAP_PAGE_MASK;
      rwap_pkg::RWAP_SECTOR: msk = `RWAP_SECT_MASK;
      rwap_pkg::RWAP_BLOCK:  msk = `RWAP_BLK_MASK;
      rwap_pkg::RWAP_CHIP:   msk = `RWAP_ADDR_MAX;
    endcase
  end

  assign rg_lo = op_addr_q & ~msk;
  assign rg_hi = op_addr_q | msk;

  // any overlap with the protected set refuses the whole operation
  always_comb begin
    if (cfg_q.invert_protection) begin
      hit = !rng.en || (rg_lo < rng.lo) || (rg_hi > rng.hi);
    end else begin
      hit = rng.en && (rg_lo <= rng.hi) && (rg_hi >= rng.lo);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      op_refused_o <= 1'b0;
      accepted_q   <= 1'b0;
      op_go_o      <= 1'b0;
    end else begin
      op_go_o <= chk_q && !hit;
      if (chk_q) begin
        op_refused_o <= hit;
        accepted_q   <= !hit;
      end
    end
  end

  // ==========================================================
  // read sequencer; chip select high returns it to idle
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      st_q           <= rwap_pkg::RWAP_ST_IDLE;
      dcnt_q         <= 4'h0;
      cnt_lat_q      <= 4'h0;
      dummy_active_o <= 1'b0;
      data_drive_o   <= 1'b0;
    end else if (cs_s2_q) begin
      st_q           <= rwap_pkg::RWAP_ST_IDLE;
      dummy_active_o <= 1'b0;
      data_drive_o   <= 1'b0;
    end else begin
      unique case (st_q)
        rwap_pkg::RWAP_ST_IDLE: begin
          if (cs_fall) begin
            dcnt_q         <= lut_cnt;
            cnt_lat_q      <= lut_cnt;
            st_q           <= rwap_pkg::RWAP_ST_WAIT;
            dummy_active_o <= 1'b1;
          end
        end
        rwap_pkg::RWAP_ST_WAIT: begin
          if (sclk_rise) begin
            if (dcnt_q == 4'h1) begin
              st_q           <= rwap_pkg::RWAP_ST_DATA;
              dummy_active_o <= 1'b0;
              data_drive_o   <= 1'b1;
            end else begin
              dcnt_q <= dcnt_q - 4'h1;
            end
          end
        end
        rwap_pkg::RWAP_ST_DATA: data_drive_o <= 1'b1;
        default: begin
          st_q           <= rwap_pkg::RWAP_ST_IDLE;
          dummy_active_o <= 1'b0;
          data_drive_o   <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!resetn_i);

  sequence s_read_start;
    st_q == rwap_pkg::RWAP_ST_IDLE && !cs_s2_q && cs_fall;
  endsequence
  sequence s_last_dummy;
    st_q == rwap_pkg::RWAP_ST_WAIT && dcnt_q == 4'h1 && sclk_rise && !cs_s2_q;
  endsequence
  property p_sample_wait;
    s_read_start |=> dummy_active_o && dcnt_q == $past(lut_cnt);
  endproperty
  a_sample_wait: assert property (p_sample_wait)
    else $error("dummy count not sampled at read start");
  property p_data_after_dummy;
    s_last_dummy |=> data_drive_o && !dummy_active_o;
  endproperty
  a_data_after_dummy: assert property (p_data_after_dummy)
    else $error("data not driven after last dummy clock");
  property p_single_eight;
    (form_q == rwap_pkg::RWAP_FAST || form_q == rwap_pkg::RWAP_DUAL_OUT ||
     form_q == rwap_pkg::RWAP_QUAD_OUT) |-> lut_cnt == 4'h8;
  endproperty
  a_single_eight: assert property (p_single_eight)
    else $error("single rate fast read wait not 8");
  property p_dual_io;
    (form_q == rwap_pkg::RWAP_DUAL_IO && !cfg_q.read_wait_select[0])
      |-> lut_cnt == 4'h4;
  endproperty
  a_dual_io: assert property (p_dual_io)
    else $error("dual io wait not 4");
  property p_quad_io;
    (form_q == rwap_pkg::RWAP_QUAD_IO && cfg_q.read_wait_select == 2'b00)
      |-> lut_cnt == 4'h6;
  endproperty
  a_quad_io: assert property (p_quad_io)
    else $error("quad io default wait not 6");
  property p_dtr_fast;
    (form_q == rwap_pkg::RWAP_DTR_FAST && cfg_q.read_wait_select == 2'b11)
      |-> lut_cnt == 4'hA;
  endproperty
  a_dtr_fast: assert property (p_dtr_fast)
    else $error("double rate fast wait not 10");
  property p_dtr_quad;
    (form_q == rwap_pkg::RWAP_DTR_QUAD_IO && cfg_q.read_wait_select == 2'b10)
      |-> lut_cnt == 4'h6;
  endproperty
  a_dtr_quad: assert property (p_dtr_quad)
    else $error("double rate quad io wait not 6");
  property p_cfg_upper_zero;
    $rose(pready_o) && !pwrite_i && paddr_i == 32'h0000_0000
      |-> prdata_o[31:8] == 24'h00_0000;
  endproperty
  a_cfg_upper_zero: assert property (p_cfg_upper_zero)
    else $error("reserved config bits read nonzero");
  property p_none_protected;
    chk_q && !cfg_q.invert_protection && cfg_q.protect_size_code == 3'h0
      |=> !op_refused_o && op_go_o;
  endproperty
  a_none_protected: assert property (p_none_protected)
    else $error("size code zero refused an operation");
  property p_all_protected;
    chk_q && !cfg_q.invert_protection && cfg_q.protect_size_code == 3'h7
      |=> op_refused_o && !op_go_o;
  endproperty
  a_all_protected: assert property (p_all_protected)
    else $error("size code all ones let an operation pass");
  property p_block_top;
    !cfg_q.small_unit_select && !cfg_q.protect_from_low_end &&
      cfg_q.protect_size_code == 3'h1 |-> rng.lo == 23'h7E_0000;
  endproperty
  a_block_top: assert property (p_block_top)
    else $error("top 1/64 window wrong");
  property p_block_low;
    !cfg_q.small_unit_select && cfg_q.protect_from_low_end &&
      cfg_q.protect_size_code == 3'h6 |-> rng.hi == 23'h3F_FFFF;
  endproperty
  a_block_low: assert property (p_block_low)
    else $error("low half window wrong");
  property p_sector_top;
    cfg_q.small_unit_select && !cfg_q.protect_from_low_end &&
      cfg_q.protect_size_code == 3'h1 |-> rng.lo == 23'h7F_F000;
  endproperty
  a_sector_top: assert property (p_sector_top)
    else $error("top sector window wrong");
  property p_sector_low;
    cfg_q.small_unit_select && cfg_q.protect_from_low_end &&
      cfg_q.protect_size_code[2:1] == 2'b10 |-> rng.hi == 23'h00_7FFF;
  endproperty
  a_sector_low: assert property (p_sector_low)
    else $error("low 32KB window wrong");
  property p_inverted_none;
    chk_q && cfg_q.invert_protection && cfg_q.protect_size_code == 3'h0
      |=> op_refused_o;
  endproperty
  a_inverted_none: assert property (p_inverted_none)
    else $error("inverted empty window did not protect all");

endmodule : rwap_top

// *** rwap_top_tb.sv ***
`timescale 1ns/100ps
`include "rwap_defs.svh"

module rwap_top_tb;
  logic        core_clk_i, resetn_i, psel_i, penable_i, pwrite_i;
  logic [31:0] paddr_i, pwdata_i, prdata_o, rd;
  logic        pready_o, pslverr_o, err, sclk_i, cs_n_i, go, slow, busy;
  logic        dummy_active_o, data_drive_o, op_go_o, op_refused_o, e;
  logic [7:0]  cfg;
  logic [22:0] adr;
  logic [1:0]  knd;
  logic [35:0] corner [10];
  int          n_mismatch, compares, cyc, nrise, seen_n, x, seed;

  rwap_top u_rwap_top (
    .core_clk_i(core_clk_i), .resetn_i(resetn_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .pready_o(pready_o), .prdata_o(prdata_o),
    .pslverr_o(pslverr_o), .sclk_i(sclk_i), .cs_n_i(cs_n_i),
    .dummy_active_o(dummy_active_o), .data_drive_o(data_drive_o),
    .op_go_o(op_go_o), .op_refused_o(op_refused_o));

  rwap_host_model u_rwap_host_model (
    .go_i(go), .slow_i(slow), .sclk_o(sclk_i), .cs_n_o(cs_n_i),
    .busy_o(busy));

  initial begin
    core_clk_i = 1'b0;
    forever #2.5 core_clk_i = ~core_clk_i;
  end

  // ==========================================================
  // checking and closing
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic finish_test;
    if (n_mismatch == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : finish_test

  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 40000) begin
      n_mismatch++;
      finish_test();
    end
  end

  // ==========================================================
  // apb master: ends one edge after the answer so drives never collide
  task automatic apb(input logic wr, input logic [31:0] a,
                     input logic [31:0] wd);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= wr;
    paddr_i   <= a;
    pwdata_i  <= wd;
    @(posedge core_clk_i);
    penable_i <= 1'b1;
    // no fixed wait assumed; the cycle ceiling ends a hang
    do begin
      @(posedge core_clk_i);
    end while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
    @(posedge core_clk_i);
  endtask : apb

  // ==========================================================
  // expected values
  function automatic logic [3:0] exp_dummy(input logic [3:0] f,
                                           input logic [1:0] s);
    case (f)
      4'h3, 4'h4:       return s[0] ? 4'h8 : 4'h4;
      4'h5, 4'h6, 4'h7: return (s == 2'b00) ? 4'h6 : (s == 2'b01) ? 4'h4 :
                               (s == 2'b10) ? 4'h8 : 4'hA;
      4'h8:             return (s == 2'b00) ? 4'h8 : (s == 2'b01) ? 4'h4 :
                               (s == 2'b10) ? 4'h6 : 4'hA;
      default:          return 4'h8;
    endcase
  endfunction : exp_dummy

  function automatic logic exp_refused(input logic [7:0] c,
                                       input logic [22:0] a,
                                       input logic [1:0] k);
    logic [23:0] sz, lo, hi, rs, rlo, rhi;
    logic [2:0]  cd;
    cd = c[6:4];
    sz = c[2] ? (24'h00_1000 << ((cd > 3'd3) ? 3'd3 : cd - 3'd1))
              : (24'h01_0000 << cd);
    lo = c[3] ? 24'h00_0000 : 24'h80_0000 - sz;
    hi = lo + sz - 24'h00_0001;
    if (cd == 3'd7) begin
      lo = 24'h00_0000;
      hi = 24'h7F_FFFF;
    end
    rs = (k == 2'd0) ? 24'h00_0100 : (k == 2'd1) ? 24'h00_1000 :
         (k == 2'd2) ? 24'h01_0000 : 24'h80_0000;
    rlo = {1'b0, a} & ~(rs - 24'h00_0001);
    rhi = rlo + rs - 24'h00_0001;
    if (c[7])
      return (cd == 3'd0) || (cd != 3'd7 && (rlo < lo || rhi > hi));
    return (cd != 3'd0) && rlo <= hi && rhi >= lo;
  endfunction : exp_refused

  // ==========================================================
  // link observation: rises counted from chip select fall
  always @(negedge cs_n_i) nrise = 0;
  always @(posedge sclk_i) nrise++;
  always @(posedge data_drive_o) seen_n = nrise;

  task automatic screen(input logic [7:0] c, input logic [22:0] a,
                        input logic [1:0] k);
    apb(1'b1, 32'h0000_0000, {24'h00_0000, c});
    apb(1'b1, 32'h0000_0008, {9'h000, a});
    apb(1'b1, 32'h0000_000C, {30'h0000_0000, k});
    // go pulse stands for the cycle after the task's closing edge, one edge past the answer; look mid-cycle
    @(negedge core_clk_i);
    e = exp_refused(c, a, k);
    chk({31'h0, op_refused_o}, {31'h0, e});
    chk({31'h0, op_go_o}, {31'h0, ~e});
    @(posedge core_clk_i);
  endtask : screen

  // ==========================================================
  // main sequence
  initial begin
    seed = 32'hf5b1_1a2e;
    {resetn_i, psel_i, penable_i, pwrite_i, go, slow} = 6'b000000;
    paddr_i = 32'h0000_0000;
    pwdata_i = 32'h0000_0000;
    // corner fields: cfg [35:28], kind [25:24], address [22:0]
    corner = '{36'h1_007D_FF00, 36'h1_007E_0000, 36'h5_407F_7F00,
               36'h5_407F_8000, 36'h5_C000_7F00, 36'h5_C000_8000,
               36'h9_007E_0000, 36'h9_007D_FF00, 36'h1_8202_0000,
               36'hF_0300_0000};
    repeat (4) @(posedge core_clk_i);
    resetn_i <= 1'b1;
    @(posedge core_clk_i);
    apb(1'b0, 32'h0000_0000, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    apb(1'b0, 32'h0000_0010, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    apb(1'b1, 32'h0000_0000, 32'hFFFF_FF00);
    apb(1'b0, 32'h0000_0000, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    apb(1'b0, 32'h0000_1000, 32'h0000_0000);
    chk({rd[30:0], err}, 32'h0000_0001);
    // wait counts; select flipped mid-frame must not matter
    for (int f = 0; f < 10; f++) begin
      for (int s = 0; s < 4; s++) begin
        apb(1'b1, 32'h0000_0000, s);
        apb(1'b1, 32'h0000_0004, f);
        seen_n = 0;
        slow <= 1'($random(seed));
        go <= 1'b1;
        while (dummy_active_o !== 1'b1) begin
          @(posedge core_clk_i);
        end
        go <= 1'b0;
        apb(1'b1, 32'h0000_0000, s ^ 3);
        while (busy !== 1'b0) begin
          @(posedge core_clk_i);
        end
        chk(seen_n, exp_dummy(4'(f), 2'(s)));
        apb(1'b0, 32'h0000_0010, 32'h0000_0000);
        chk(rd & 32'h0000_00FC, {exp_dummy(4'(f), 2'(s)), 2'b00});
      end
    end
    // protection: corners, then random with ends weighted
    foreach (corner[i])
      screen(corner[i][35:28], corner[i][22:0], corner[i][25:24]);
    repeat (250) begin
      cfg = 8'($random(seed));
      knd = 2'($random(seed));
      x = $random(seed);
      adr = x[0] ? 23'($random(seed)) :
            x[1] ? 23'h7F_FFFF - 23'(x[31:16]) : 23'(x[31:16]);
      screen(cfg, adr, knd);
    end
    finish_test();
  end
endmodule : rwap_top_tb
